// ### src/dacw_pkg.sv
// package: constants and carriers for the i2c write receiver of a quad dac
// assumes: used by src/dacw_top.sv only, referenced as dacw_pkg::name
package dacw_pkg;
    localparam logic [4:0] ADDR_FIXED = 5'h13;
    localparam int ADDR_FIXED_MSB = 7;
    localparam int ADDR_FIXED_LSB = 3;
    localparam int CTRL_EXT_HI = 7;
    localparam int CTRL_EXT_LO = 6;
    localparam int CTRL_LOAD_MSB = 5;
    localparam int CTRL_LOAD_LSB = 4;
    localparam int CTRL_CHAN_MSB = 2;
    localparam int CTRL_CHAN_LSB = 1;
    localparam int CTRL_PD_FLAG = 0;
    localparam logic [4:0] HS_CODE = 5'h01;
    localparam int NUM_CHAN = 4;
    localparam int CHAN_W = 18;
    localparam logic [17:0] CHAN_RESET = 18'h00000;
    localparam int FIFO_DEPTH = 8;
    localparam int WORD_W = 20;

    typedef enum logic [1:0] {
        REQ_DATA,
        REQ_POWERDOWN
    } req_kind_t;

    // one finished word as it travels through the fifo
    typedef struct packed {
        req_kind_t kind;
        logic [1:0] chan;
        logic [15:0] value;
    } word_t;

    // control byte, msb first: extended address, load mode, spare, channel, flag
    typedef struct packed {
        logic ext_addr_bit_hi;
        logic ext_addr_bit_lo;
        logic [1:0] load_mode;
        logic spare;
        logic [1:0] chan;
        logic powerdown_payload_flag;
    } ctrl_t;
endpackage : dacw_pkg

// ### src/dacw_top.sv
// file: i2c write receiver with word fifo and channel holding registers
// assumes: scl and sda arrive unsynchronised; sda open drain resolved outside
//
// How it works
// - transaction is write address then control byte
// - control byte selects operation and channel
// - control bit zero picks powerdown or data
// - data pairs repeat until stop, restart, or a full fifo refuses the closing byte
// - powerdown mode takes exactly two bytes
// - address is 10011, pin bits, direction bit
// - control fields: ext, load, spare, channel, flag
// - high byte first, then low byte
// - acknowledge address, control and data bytes
// - hs master code is never acknowledged
// - after hs code, restart and normal handling
// - word enters the fifo at falling edge ending ack
// - channel select 0..3 picks channel a..d
// - 18-bit holding and output per channel
`timescale 1ns/1ps
`default_nettype none

module dacw_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = AW'(0) + cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
    end

    assign o_in_ready = cnt_q != (AW+1)'(DEPTH);
    assign o_out_valid = cnt_q != '0;
    assign o_out_data = mem[rd_q];
endmodule // dacw_fifo

module dacw_top (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_addr_pin_sel_hi,
    input wire logic i_addr_pin_sel_lo,
    input wire logic i_apply_ready,
    output logic o_fifo_ready,
    output logic o_hs_mode,
    output logic [1:0] o_load_mode,
    output logic [dacw_pkg::NUM_CHAN*dacw_pkg::CHAN_W-1:0] o_holding
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CTRL,
        ST_HIGH,
        ST_LOW,
        ST_PD_HI,
        ST_PD_LO,
        ST_IGNORE
    } state_t;

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] scl_sync_q, sda_sync_q;
    logic scl_q, sda_q;
    logic [1:0] pin_meta_q, pin_sel_q;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            pin_meta_q <= 2'h0;
            pin_sel_q <= 2'h0;
        end else begin
            scl_sync_q <= {scl_sync_q[0], i_scl};
            sda_sync_q <= {sda_sync_q[0], i_sda};
            pin_meta_q <= {i_addr_pin_sel_hi, i_addr_pin_sel_lo};
            pin_sel_q <= pin_meta_q;
            scl_q <= scl_sync_q[1];
            sda_q <= sda_sync_q[1];
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl_sync_q[1] && !scl_q;
    assign scl_fall = !scl_sync_q[1] && scl_q;
    assign start_seen = scl_sync_q[1] && scl_q && sda_q && !sda_sync_q[1];
    assign stop_seen = scl_sync_q[1] && scl_q && !sda_q && sda_sync_q[1];

    // ------------------------------------------------------------
    // byte receiver and protocol state
    // ------------------------------------------------------------
    state_t st_q, st_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bit_q, bit_d;
    logic ack_q, ack_d;
    logic ack_phase_q, ack_phase_d;
    logic hs_q, hs_d;
    logic commit_q, commit_d;
    dacw_pkg::ctrl_t ctrl_q, ctrl_d;
    logic [7:0] high_q, high_d;
    logic push;
    dacw_pkg::word_t word;
    logic fifo_in_ready;

    logic [7:0] rx_byte;
    logic byte_done, addr_match;
    assign rx_byte = {shift_q[6:0], sda_q};
    assign byte_done = scl_rise && bit_q == 4'h7 && !ack_phase_q;
    assign addr_match = rx_byte[dacw_pkg::ADDR_FIXED_MSB:dacw_pkg::ADDR_FIXED_LSB]
        == dacw_pkg::ADDR_FIXED && rx_byte[2] == pin_sel_q[1]
        && rx_byte[1] == pin_sel_q[0] && !rx_byte[0];

    always_comb begin
        st_d = st_q;
        shift_d = shift_q;
        bit_d = bit_q;
        ack_d = ack_q;
        ack_phase_d = ack_phase_q;
        hs_d = hs_q;
        ctrl_d = ctrl_q;
        high_d = high_q;
        commit_d = commit_q;
        push = 1'b0;
        // the closing byte sits whole in shift_q once the ack bit has begun
        word = '{kind: dacw_pkg::REQ_DATA, chan: ctrl_q.chan, value: {high_q, shift_q}};
        if (ctrl_q.powerdown_payload_flag) begin
            word.kind = dacw_pkg::REQ_POWERDOWN;
        end
        if (start_seen) begin
            // restart or start drops any half pair
            st_d = ST_ADDR;
            bit_d = '0;
            ack_d = 1'b0;
            ack_phase_d = 1'b0;
            commit_d = 1'b0;
        end else if (stop_seen) begin
            st_d = ST_IDLE;
            ack_d = 1'b0;
            hs_d = 1'b0;
            commit_d = 1'b0;
        end else if (st_q != ST_IDLE) begin
            if (scl_rise && !ack_phase_q) begin
                shift_d = rx_byte;
                bit_d = 4'(bit_q + 1'b1);
            end
            if (byte_done) begin
                ack_d = 1'b1;
                case (st_q)
                    ST_ADDR: begin
                        if (rx_byte[7:3] == dacw_pkg::HS_CODE) begin
                            ack_d = 1'b0;
                            hs_d = 1'b1;
                            st_d = ST_IGNORE;
                        end else if (addr_match) begin
                            st_d = ST_CTRL;
                        end else begin
                            ack_d = 1'b0;
                            st_d = ST_IGNORE;
                        end
                    end
                    ST_CTRL: begin
                        ctrl_d = dacw_pkg::ctrl_t'(rx_byte);
                        st_d = rx_byte[dacw_pkg::CTRL_PD_FLAG] ? ST_PD_HI : ST_HIGH;
                    end
                    ST_HIGH: begin
                        high_d = rx_byte;
                        st_d = ST_LOW;
                    end
                    ST_LOW: st_d = ST_HIGH;
                    ST_PD_HI: begin
                        high_d = rx_byte;
                        st_d = ST_PD_LO;
                    end
                    ST_PD_LO: st_d = ST_IGNORE;
                    default: begin
                        // bytes past the end of a transfer are never acknowledged
                        ack_d = 1'b0;
                        st_d = ST_IGNORE;
                    end
                endcase
                // only the closing byte of a pair or of a powerdown word commits
                commit_d = (st_q == ST_LOW || st_q == ST_PD_LO) && fifo_in_ready;
                if (!fifo_in_ready && (st_q == ST_LOW || st_q == ST_PD_LO)) begin
                    // no room: refuse the closing byte rather than lose it
                    ack_d = 1'b0;
                    st_d = ST_IGNORE;
                end
            end
            if (scl_fall && bit_q == 4'h8 && !ack_phase_q) begin
                ack_phase_d = 1'b1;
            end else if (scl_fall && ack_phase_q) begin
                // falling edge that ends the ack bit commits the word
                ack_phase_d = 1'b0;
                bit_d = '0;
                if (ack_q && commit_q) begin
                    push = 1'b1;
                end
                ack_d = 1'b0;
                commit_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= ST_IDLE;
            shift_q <= '0;
            bit_q <= '0;
            ack_q <= 1'b0;
            ack_phase_q <= 1'b0;
            hs_q <= 1'b0;
            ctrl_q <= '0;
            high_q <= '0;
            commit_q <= 1'b0;
        end else begin
            st_q <= st_d;
            shift_q <= shift_d;
            bit_q <= bit_d;
            ack_q <= ack_d;
            ack_phase_q <= ack_phase_d;
            hs_q <= hs_d;
            ctrl_q <= ctrl_d;
            high_q <= high_d;
            commit_q <= commit_d;
        end
    end

    // open drain: drive low only during an acknowledged bit
    assign o_sda_out = 1'b0;
    assign o_sda_oe = ack_q && ack_phase_q;
    assign o_hs_mode = hs_q;
    assign o_load_mode = ctrl_q.load_mode;
    assign o_fifo_ready = fifo_in_ready;

    // ------------------------------------------------------------
    // fifo and channel holding registers
    // ------------------------------------------------------------
    dacw_pkg::word_t out_word;
    logic out_valid;

    dacw_fifo #(.WIDTH(dacw_pkg::WORD_W), .DEPTH(dacw_pkg::FIFO_DEPTH)) u_fifo (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_in_valid(push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(word),
        .o_out_valid(out_valid),
        .i_out_ready(i_apply_ready),
        .o_out_data(out_word)
    );

    logic [dacw_pkg::CHAN_W-1:0] hold_q [dacw_pkg::NUM_CHAN];
    logic [dacw_pkg::CHAN_W-1:0] hold_d [dacw_pkg::NUM_CHAN];

    always_comb begin
        for (int i = 0; i < dacw_pkg::NUM_CHAN; i++) begin
            hold_d[i] = hold_q[i];
        end
        if (out_valid && i_apply_ready) begin
            if (out_word.kind == dacw_pkg::REQ_POWERDOWN) begin
                hold_d[out_word.chan][17:16] = out_word.value[15:14];
            end else begin
                hold_d[out_word.chan][15:0] = out_word.value;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < dacw_pkg::NUM_CHAN; i++) begin
                hold_q[i] <= dacw_pkg::CHAN_RESET;
            end
        end else begin
            for (int i = 0; i < dacw_pkg::NUM_CHAN; i++) begin
                hold_q[i] <= hold_d[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < dacw_pkg::NUM_CHAN; i++) begin
            o_holding[i*dacw_pkg::CHAN_W +: dacw_pkg::CHAN_W] = hold_q[i];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    ack_on_match_a: assert property (byte_done && st_q == ST_ADDR && addr_match
        && !start_seen && !stop_seen |=> ack_q && st_q == ST_CTRL)
        else $error("matching address not acknowledged");
    no_ack_mismatch_a: assert property (byte_done && st_q == ST_ADDR && !addr_match
        && !start_seen && !stop_seen |=> !ack_q)
        else $error("foreign address acknowledged");
    hs_code_nack_a: assert property (byte_done && st_q == ST_ADDR
        && rx_byte[7:3] == dacw_pkg::HS_CODE && !start_seen && !stop_seen |=> !ack_q && hs_q)
        else $error("hs code acknowledged");
    pd_flag_route_a: assert property (byte_done && st_q == ST_CTRL && rx_byte[0]
        && !start_seen && !stop_seen |=> st_q == ST_PD_HI)
        else $error("powerdown flag ignored");
    pair_cycle_a: assert property (byte_done && st_q == ST_LOW && fifo_in_ready
        && !start_seen && !stop_seen |=> st_q == ST_HIGH)
        else $error("data pairs do not repeat");
    stop_drops_a: assert property (stop_seen && st_q == ST_LOW |=> !push && st_q == ST_IDLE)
        else $error("half pair kept at stop");
    push_on_ack_fall_a: assert property (push |-> scl_fall && ack_phase_q && $past(ack_q))
        else $error("word committed off the ack edge");
    apply_word_a: assert property (out_valid && i_apply_ready
        && out_word.kind == dacw_pkg::REQ_DATA |=> hold_q[$past(out_word.chan)][15:0]
        == $past(out_word.value))
        else $error("channel not updated");
    // sda may only move while scl is low, or the master would see a start or stop
    sda_steady_a: assert property (scl_sync_q[1] && scl_q |=> $stable(o_sda_oe))
        else $error("sda moved while scl high");

    cover property (push && st_q == ST_HIGH);
    cover property (push && st_q == ST_IGNORE);
    cover property (hs_q && st_q == ST_CTRL);
    cover property (!fifo_in_ready);
endmodule // dacw_top

`default_nettype wire

// ### dv/i2c_master_model.sv
// i2c master model: drives scl, pulls sda low, samples the ack bit
// assumes: sda is resolved with a pull-up in the bench; scl idles high
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input wire logic i_clock,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic wait_half();
        repeat (4) @(posedge i_clock);
    endtask
    // sda moves mid-low so no edge of scl ever coincides with it
    task automatic clock_bit(input logic low, output logic seen);
        repeat (2) @(posedge i_clock);
        o_sda_low <= low;
        repeat (2) @(posedge i_clock);
        o_scl <= 1'b1;
        wait_half();
        seen = i_sda;
        o_scl <= 1'b0;
    endtask
    task automatic start();
        repeat (2) @(posedge i_clock);
        o_sda_low <= 1'b0;
        repeat (2) @(posedge i_clock);
        o_scl <= 1'b1;
        wait_half();
        o_sda_low <= 1'b1;
        wait_half();
        o_scl <= 1'b0;
    endtask
    task automatic stop();
        repeat (2) @(posedge i_clock);
        o_sda_low <= 1'b1;
        repeat (2) @(posedge i_clock);
        o_scl <= 1'b1;
        wait_half();
        o_sda_low <= 1'b0;
        wait_half();
    endtask
    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(!b[i], s);
        end
        clock_bit(1'b0, s);
        ack = !s;
    endtask
endmodule // i2c_master_model
`default_nettype wire

// ### dv/dacw_top_bench.sv
// bench: master model writes over i2c, holdings compared with a model
// assumes: dacw_pkg and dacw_top compiled first
`timescale 1ns/1ps
`default_nettype none
module dacw_top_bench;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] pins = 2'h0;
    logic apply = 1'b1;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic fifo_ready;
    logic hs_mode;
    logic [1:0] load_mode;
    logic [71:0] holding;
    wire logic sda = !(sda_low || (sda_oe && !sda_out));
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] rnd = 16'h6C07;
    logic [17:0] mdl [4] = '{default: 18'h00000};
    logic [15:0] last;

    always #5 clock = ~clock;

    i2c_master_model m (.i_clock(clock), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
    dacw_top dut (
        .i_clock(clock), .i_nrst(nrst), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_addr_pin_sel_hi(pins[1]), .i_addr_pin_sel_lo(pins[0]),
        .i_apply_ready(apply), .o_fifo_ready(fifo_ready), .o_hs_mode(hs_mode),
        .o_load_mode(load_mode), .o_holding(holding)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] addr();
        return {5'h13, pins, 1'b0};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic a;
        m.byte_out(b, a);
        chk(72'(a), 72'(exp_ack));
    endtask
    // words land a few clocks after the ack ends, so give them time
    task automatic settle();
        repeat (12) @(posedge clock);
        chk(holding, {mdl[3], mdl[2], mdl[1], mdl[0]});
    endtask
    task automatic wr_data(input logic [1:0] ch, input int pairs, input logic [1:0] ld);
        m.start();
        put(addr(), 1'b1);
        put({2'h0, ld, 1'b0, ch, 1'b0}, 1'b1);
        for (int p = 0; p < pairs; p++) begin
            rnd = lfsr(rnd);
            put(rnd[15:8], 1'b1);
            put(rnd[7:0], 1'b1);
            mdl[ch][15:0] = rnd;
        end
        chk(72'(load_mode), 72'(ld));
        m.stop();
    endtask
    task automatic wr_pd(input logic [1:0] ch, input logic [1:0] pd);
        m.start();
        put(addr(), 1'b1);
        put({5'h00, ch, 1'b1}, 1'b1);
        put({pd, 6'h00}, 1'b1);
        put(8'h00, 1'b1);
        put(8'h00, 1'b0);
        m.stop();
        mdl[ch][17:16] = pd;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        pins <= rnd[1:0];
        repeat (6) @(posedge clock);
        settle();
        chk(72'(hs_mode), 72'h0);
        for (int c = 0; c < 4; c++) wr_data(2'(c), 2, 2'(c));
        settle();
        $display("test data pairs done");
        for (int c = 0; c < 4; c++) wr_pd(2'(c), 2'(3 - c));
        settle();
        $display("test powerdown done");
        m.start();
        put(addr() ^ 8'h04, 1'b0);
        put(8'h00, 1'b0);
        m.stop();
        m.start();
        put(addr(), 1'b1);
        put(8'h02, 1'b1);
        put(8'hAB, 1'b1);
        m.stop();
        settle();
        $display("test refusals done");
        m.start();
        put(8'h0D, 1'b0);
        chk(72'(hs_mode), 72'h1);
        wr_data(2'h1, 1, 2'h2);
        settle();
        chk(72'(hs_mode), 72'h0);
        $display("test high speed done");
        apply <= 1'b0;
        m.start();
        put(addr(), 1'b1);
        put(8'h00, 1'b1);
        for (int k = 0; k < 9; k++) begin
            rnd = lfsr(rnd);
            put(rnd[15:8], 1'b1);
            put(rnd[7:0], k < 8);
            if (k < 8) last = rnd;
        end
        m.stop();
        chk(72'(fifo_ready), 72'h0);
        settle();
        apply <= 1'b1;
        mdl[0][15:0] = last;
        settle();
        chk(72'(fifo_ready), 72'h1);
        $display("test fifo full done");
        report_and_stop();
    end
endmodule // dacw_top_bench
`default_nettype wire
